// ### cicsr_defs.svh
// constants for the cpu identity, boot option and operating mode registers
// Overview of operation
// - identity register read-only, revision and implementation bytes
// - revision byte holds major and minor nibbles
// - identity upper halfword always reads zero
// - stream option fields captured at reset, read-only
// - boot bits 12 and 3:0 software read/write
// - bit 31 copies stream bit 25, cache absent
// - bits 30:28 copy stream clock ratio bits
// - bits 27:24 copy stream write-back pattern bits
// - block size field fixed at eight-word code
// - bits 21:20 copy stream identifier bits 17:16
// - bit 17 copies stream bit 12, tertiary absent
// - bit 16 copies stream half-multiplier bit 20
// - bit 15 is stream bit 8 or pin
// - check mode and block order read as one
// - bit 12 enables the tertiary cache controller
// - cache size fields report fixed 16 kilobytes
// - cache line-size bits read one, 32 bytes
// - bit 3 enables l2, 2:0 segment policy
// - reverse-endian bit inverts byte order in user only
// - mask bits gate interrupts, bit 7 timer-or-ext5
// - usability field gates coprocessors, cp0 kernel always
// - mode bit 31 allows extended isa in user
`ifndef CICSR_DEFS_SVH
`define CICSR_DEFS_SVH

// ----------------------------------------------------------------
// register addresses and port widths
// ----------------------------------------------------------------
`define CICSR_AW         5
`define CICSR_A_MODE     5'h0c
`define CICSR_A_ID       5'h0f
`define CICSR_A_BOOT     5'h10
`define CICSR_MODE_W     27

// ----------------------------------------------------------------
// mode stream bit positions
// ----------------------------------------------------------------
`define CICSR_MB_WBP_LO  1
`define CICSR_MB_WBP_HI  4
`define CICSR_MB_RAT_LO  5
`define CICSR_MB_RAT_HI  7
`define CICSR_MB_ENDIAN  8
`define CICSR_MB_TMR     11
`define CICSR_MB_L3      12
`define CICSR_MB_SI_LO   16
`define CICSR_MB_SI_HI   17
`define CICSR_MB_HALF    20
`define CICSR_MB_L2      25

// ----------------------------------------------------------------
// fixed field values and reset values
// ----------------------------------------------------------------
`define CICSR_SB_8WORD   2'h1
`define CICSR_BUS_64     2'h0
`define CICSR_SIZE_16K   3'h2
`define CICSR_FIXED_ONE  1'h1
`define CICSR_REG_RST    32'h0000_0000
`define CICSR_CP_LAST    2'h2

`endif

// ### cicsr_pkg.sv
// types for the cpu identity, boot option and operating mode registers
package cicsr_pkg;

  // boot option readback layout, msb first
  typedef struct packed {
    logic       l2_absent_flag;
    logic [2:0] clock_ratio_code;
    logic [3:0] writeback_pattern;
    logic [1:0] l2_block_size;
    logic [1:0] sys_ident;
    logic [1:0] bus_width;
    logic       l3_absent_flag;
    logic       half_clock_flag;
    logic       byte_order_flag;
    logic       check_mode_flag;
    logic       block_order_flag;
    logic       l3_enable;
    logic [2:0] icache_size_code;
    logic [2:0] dcache_size_code;
    logic       icache_line_flag;
    logic       dcache_line_flag;
    logic       l2_enable;
    logic [2:0] kernel_segment_policy;
  } cicsr_boot_t;

  // operating mode layout, only the kept fields are live
  typedef struct packed {
    logic       ext_isa_user_enable;
    logic [2:0] coproc_usable;
    logic [1:0] rsvd_hi;
    logic       user_endian_invert;
    logic [8:0] rsvd_diag;
    logic [7:0] interrupt_mask;
    logic [7:0] rsvd_lo;
  } cicsr_mode_t;

  // privilege level of the running code
  typedef enum logic [1:0] {
    CICSR_KERNEL = 2'b00,
    CICSR_SUPER  = 2'b01,
    CICSR_USER   = 2'b10
  } cicsr_priv_t;

endpackage : cicsr_pkg

// ### cicsr_regs.sv
// identity, boot option and operating mode registers with their side effects
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "cicsr_defs.svh"

module cicsr_regs #(
  parameter logic [3:0] REV_MAJOR = 4'h1,
  parameter logic [3:0] REV_MINOR = 4'h0,
  parameter logic [7:0] IMP_CODE  = 8'h5a  // arbitrary value
) (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic [`CICSR_AW-1:0]      addr,
  input  wire logic [31:0]               wdata,
  input  wire logic                      wr_en,
  input  wire logic                      rd_en,
  output logic      [31:0]               rdata,
  input  wire logic [`CICSR_MODE_W-1:0]  mode_bits,
  input  wire logic                      big_endian_pin,
  input  wire cicsr_pkg::cicsr_priv_t    priv,
  input  wire logic [1:0]                sw_int,
  input  wire logic [5:0]                ext_int,
  input  wire logic                      timer_int,
  input  wire logic                      cop_access,
  input  wire logic [1:0]                cop_num,
  output logic      [7:0]                int_request,
  output logic                           cop_fault,
  output logic                           data_big_endian,
  output logic                           ext_isa_ok,
  output logic                           l3_enable,
  output logic                           l2_enable,
  output logic      [2:0]                kernel_segment_policy,
  output logic                           boot_done
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // address match, shared by the write and the read path
  function automatic logic addr_hit(input logic [`CICSR_AW-1:0] a,
                                    input logic [`CICSR_AW-1:0] r);
    addr_hit = (a == r);
  endfunction : addr_hit

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_n;
  logic rst_sync_n;

  // two stages so the release never lands near a clock edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  cicsr_pkg::cicsr_boot_t boot;
  cicsr_pkg::cicsr_boot_t next_boot;
  cicsr_pkg::cicsr_boot_t wboot;
  cicsr_pkg::cicsr_mode_t mode;
  cicsr_pkg::cicsr_mode_t next_mode;
  cicsr_pkg::cicsr_mode_t wmode;
  logic                   captured;
  logic                   next_captured;
  logic                   tmr_on_ext;
  logic                   next_tmr_on_ext;
  logic                   wr_boot;
  logic                   wr_mode;

  assign wboot   = cicsr_pkg::cicsr_boot_t'(wdata);
  assign wmode   = cicsr_pkg::cicsr_mode_t'(wdata);
  assign wr_boot = wr_en && addr_hit(addr, `CICSR_A_BOOT);
  assign wr_mode = wr_en && addr_hit(addr, `CICSR_A_MODE);

  // capture the stream once, in the first cycle after release;
  // a warm restart of this block would need a fresh rstn
  always_comb begin
    next_boot       = boot;
    next_mode       = mode;
    next_captured   = 1'b1;
    next_tmr_on_ext = tmr_on_ext;
    if (!captured) begin
      next_boot.l2_absent_flag    = mode_bits[`CICSR_MB_L2];
      next_boot.clock_ratio_code  =
        mode_bits[`CICSR_MB_RAT_HI:`CICSR_MB_RAT_LO];
      next_boot.writeback_pattern =
        mode_bits[`CICSR_MB_WBP_HI:`CICSR_MB_WBP_LO];
      next_boot.sys_ident         =
        mode_bits[`CICSR_MB_SI_HI:`CICSR_MB_SI_LO];
      next_boot.l3_absent_flag    = mode_bits[`CICSR_MB_L3];
      next_boot.half_clock_flag   = mode_bits[`CICSR_MB_HALF];
      next_boot.byte_order_flag   =
        mode_bits[`CICSR_MB_ENDIAN] | big_endian_pin;
      next_tmr_on_ext             = mode_bits[`CICSR_MB_TMR];
    end else if (wr_boot) begin
      // only the software fields take write data
      next_boot.l3_enable             = wboot.l3_enable;
      next_boot.l2_enable             = wboot.l2_enable;
      next_boot.kernel_segment_policy = wboot.kernel_segment_policy;
    end
    // fixed fields, rebuilt every cycle so nothing can disturb them
    next_boot.l2_block_size    = `CICSR_SB_8WORD;
    next_boot.bus_width        = `CICSR_BUS_64;
    next_boot.check_mode_flag  = `CICSR_FIXED_ONE;
    next_boot.block_order_flag = `CICSR_FIXED_ONE;
    next_boot.icache_size_code = `CICSR_SIZE_16K;
    next_boot.dcache_size_code = `CICSR_SIZE_16K;
    next_boot.icache_line_flag = `CICSR_FIXED_ONE;
    next_boot.dcache_line_flag = `CICSR_FIXED_ONE;
    if (wr_mode) begin
      next_mode.ext_isa_user_enable = wmode.ext_isa_user_enable;
      next_mode.coproc_usable       = wmode.coproc_usable;
      next_mode.user_endian_invert  = wmode.user_endian_invert;
      next_mode.interrupt_mask      = wmode.interrupt_mask;
    end
    // fields kept elsewhere read as zero here
    next_mode.rsvd_hi   = '0;
    next_mode.rsvd_diag = '0;
    next_mode.rsvd_lo   = '0;
  end

  // register the state
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      boot       <= cicsr_pkg::cicsr_boot_t'(`CICSR_REG_RST);
      mode       <= cicsr_pkg::cicsr_mode_t'(`CICSR_REG_RST);
      captured   <= 1'b0;
      tmr_on_ext <= 1'b0;
    end else begin
      boot       <= next_boot;
      mode       <= next_mode;
      captured   <= next_captured;
      tmr_on_ext <= next_tmr_on_ext;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;

  // data stand one cycle only; unmapped reads answer zero
  always_comb begin
    next_rdata = '0;
    if (rd_en) begin
      if (addr_hit(addr, `CICSR_A_ID)) begin
        next_rdata = {16'h0000, IMP_CODE, REV_MAJOR, REV_MINOR};
      end else if (addr_hit(addr, `CICSR_A_BOOT)) begin
        next_rdata = boot;
      end else if (addr_hit(addr, `CICSR_A_MODE)) begin
        next_rdata = mode;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // effects on the processor
  // ----------------------------------------------------------------
  logic [7:0] pending;
  logic       cop_ok;
  logic       is_user;
  logic [7:0] next_int_request;
  logic       next_cop_fault;
  logic       next_data_big_endian;
  logic       next_ext_isa_ok;

  assign is_user = (priv == cicsr_pkg::CICSR_USER);

  // line 7 carries the timer unless the stream routed ext 5 there
  assign pending = {tmr_on_ext ? ext_int[5] : timer_int, ext_int[4:0], sw_int};

  // cp0 is free in kernel mode; there is no usability bit for cp3
  assign cop_ok = ((cop_num == 2'h0) && (priv == cicsr_pkg::CICSR_KERNEL)) ||
                  ((cop_num <= `CICSR_CP_LAST) && mode.coproc_usable[cop_num]);

  always_comb begin
    next_int_request     = pending & mode.interrupt_mask;
    next_cop_fault       = cop_access && !cop_ok;
    next_data_big_endian = boot.byte_order_flag ^
                           (is_user && mode.user_endian_invert);
    next_ext_isa_ok      = !is_user || mode.ext_isa_user_enable;
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      int_request     <= '0;
      cop_fault       <= 1'b0;
      data_big_endian <= 1'b0;
      ext_isa_ok      <= 1'b0;
    end else begin
      int_request     <= next_int_request;
      cop_fault       <= next_cop_fault;
      data_big_endian <= next_data_big_endian;
      ext_isa_ok      <= next_ext_isa_ok;
    end
  end

  // cache controls straight from their flops
  assign l3_enable             = boot.l3_enable;
  assign l2_enable             = boot.l2_enable;
  assign kernel_segment_policy = boot.kernel_segment_policy;
  assign boot_done             = captured;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  property p_id_read;
    rd_en && addr_hit(addr, `CICSR_A_ID) |=>
      rdata[15:0] == {IMP_CODE, REV_MAJOR, REV_MINOR};
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("identity read wrong");

  property p_rev_major;
    rd_en && addr_hit(addr, `CICSR_A_ID) |=> rdata[7:4] == REV_MAJOR;
  endproperty
  a_rev_major: assert property (p_rev_major)
    else $error("major revision misplaced");

  property p_id_upper;
    $past(rd_en) && $past(addr) == `CICSR_A_ID |-> rdata[31:16] == 16'h0000;
  endproperty
  a_id_upper: assert property (p_id_upper)
    else $error("identity upper half not zero");

  property p_ratio_capture;
    $rose(captured) |->
      boot.clock_ratio_code == $past(mode_bits[`CICSR_MB_RAT_HI:`CICSR_MB_RAT_LO]);
  endproperty
  a_ratio_capture: assert property (p_ratio_capture)
    else $error("clock ratio not captured");

  property p_endian_capture;
    $rose(captured) |-> boot.byte_order_flag ==
      ($past(mode_bits[`CICSR_MB_ENDIAN]) | $past(big_endian_pin));
  endproperty
  a_endian_capture: assert property (p_endian_capture)
    else $error("byte order not captured");

  property p_ro_kept;
    captured && wr_boot |=> $stable(boot.writeback_pattern) &&
      $stable(boot.l2_absent_flag) && boot.l2_block_size == `CICSR_SB_8WORD;
  endproperty
  a_ro_kept: assert property (p_ro_kept)
    else $error("read-only boot field changed");

  property p_l3_write;
    captured && wr_boot |=> l3_enable == $past(wboot.l3_enable);
  endproperty
  a_l3_write: assert property (p_l3_write)
    else $error("tertiary enable not written");

  property p_int_gate;
    !mode.interrupt_mask[7] ##1 1 |-> !int_request[7];
  endproperty
  a_int_gate: assert property (p_int_gate)
    else $error("masked line 7 raised");

  property p_cp0_kernel;
    cop_access && cop_num == 2'h0 && priv == cicsr_pkg::CICSR_KERNEL |=> !cop_fault;
  endproperty
  a_cp0_kernel: assert property (p_cp0_kernel)
    else $error("cp0 faulted in kernel mode");

  property p_user_endian;
    !is_user |=> data_big_endian == $past(boot.byte_order_flag);
  endproperty
  a_user_endian: assert property (p_user_endian)
    else $error("non-user byte order inverted");

  property p_xisa;
    is_user && !mode.ext_isa_user_enable |=> !ext_isa_ok;
  endproperty
  a_xisa: assert property (p_xisa)
    else $error("extended isa allowed in user mode");

  property p_cache_flags_capture;
    $rose(captured) |->
      boot.l2_absent_flag == $past(mode_bits[`CICSR_MB_L2]) &&
      boot.l3_absent_flag == $past(mode_bits[`CICSR_MB_L3]);
  endproperty
  a_cache_flags_capture: assert property (p_cache_flags_capture)
    else $error("cache presence flags not captured");

  property p_pattern_capture;
    $rose(captured) |->
      boot.writeback_pattern == $past(mode_bits[`CICSR_MB_WBP_HI:`CICSR_MB_WBP_LO]);
  endproperty
  a_pattern_capture: assert property (p_pattern_capture)
    else $error("write-back pattern not captured");

  property p_ident_capture;
    $rose(captured) |->
      boot.sys_ident == $past(mode_bits[`CICSR_MB_SI_HI:`CICSR_MB_SI_LO]) &&
      boot.half_clock_flag == $past(mode_bits[`CICSR_MB_HALF]);
  endproperty
  a_ident_capture: assert property (p_ident_capture)
    else $error("identifier or half clock flag not captured");

  // geometry fields only mean something once the capture has loaded the register
  property p_geometry_fixed;
    captured |-> boot.l2_block_size == `CICSR_SB_8WORD &&
      boot.icache_size_code == `CICSR_SIZE_16K && boot.dcache_size_code == `CICSR_SIZE_16K &&
      boot.icache_line_flag && boot.dcache_line_flag;
  endproperty
  a_geometry_fixed: assert property (p_geometry_fixed)
    else $error("fixed cache geometry field wrong");

  property p_order_fixed;
    captured |-> boot.check_mode_flag && boot.block_order_flag;
  endproperty
  a_order_fixed: assert property (p_order_fixed)
    else $error("check mode or block order not fixed at one");

  property p_soft_write;
    captured && wr_boot |=> l2_enable == $past(wboot.l2_enable) &&
      kernel_segment_policy == $past(wboot.kernel_segment_policy);
  endproperty
  a_soft_write: assert property (p_soft_write)
    else $error("secondary enable or segment policy not written");

  property p_boot_read;
    rd_en && addr_hit(addr, `CICSR_A_BOOT) |=> rdata == $past(boot);
  endproperty
  a_boot_read: assert property (p_boot_read)
    else $error("boot option read wrong");

  property p_mode_write;
    wr_mode |=> mode.interrupt_mask == $past(wmode.interrupt_mask) &&
      mode.coproc_usable == $past(wmode.coproc_usable);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode register fields not written");

  c_capture: cover property ($rose(captured));
  c_boot_write: cover property (captured && wr_boot ##1 rd_en);
  c_cop_fault: cover property (cop_access ##1 cop_fault);
  c_int: cover property (|int_request);

endmodule : cicsr_regs

// ### tb_top.sv
// self-checking testbench for the identity, boot option and operating mode registers
`timescale 1ns/100ps
`include "cicsr_defs.svh"

module tb_top;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic                     clk            = 1'h0;
  logic                     rstn           = 1'h0;
  logic [`CICSR_AW-1:0]     addr           = 5'h00;
  logic [31:0]              wdata          = 32'h0;
  logic                     wr_en          = 1'h0;
  logic                     rd_en          = 1'h0;
  logic [31:0]              rdata;
  logic [`CICSR_MODE_W-1:0] mode_bits      = 27'h0;
  logic                     big_endian_pin = 1'h0;
  cicsr_pkg::cicsr_priv_t   priv           = cicsr_pkg::CICSR_KERNEL;
  logic [1:0]               sw_int         = 2'h0;
  logic [5:0]               ext_int        = 6'h00;
  logic                     timer_int      = 1'h0;
  logic                     cop_access     = 1'h0;
  logic [1:0]               cop_num        = 2'h0;
  logic [7:0]               int_request;
  logic                     cop_fault;
  logic                     data_big_endian;
  logic                     ext_isa_ok;
  logic                     l3_enable;
  logic                     l2_enable;
  logic [2:0]               kernel_segment_policy;
  logic                     boot_done;
  int                       miscompares    = 0;
  int                       checked        = 0;

  // two boot streams: a has l2 absent and half clocks, b has l3 absent and line 7 on ext5
  localparam logic [26:0] MA = 27'h212_00ac;
  localparam logic [26:0] MB = 27'h001_1850;

  always #5 clk = ~clk;

  cicsr_regs dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .mode_bits(mode_bits), .big_endian_pin(big_endian_pin),
    .priv(priv), .sw_int(sw_int), .ext_int(ext_int), .timer_int(timer_int),
    .cop_access(cop_access), .cop_num(cop_num), .int_request(int_request),
    .cop_fault(cop_fault), .data_big_endian(data_big_endian), .ext_isa_ok(ext_isa_ok),
    .l3_enable(l3_enable), .l2_enable(l2_enable),
    .kernel_segment_policy(kernel_segment_policy), .boot_done(boot_done));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task results;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  task wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'h1;
    @(posedge clk);
    wr_en <= 1'h0;
  endtask : wr

  // read data must stand for one cycle only, then drop to zero
  task rdchk(input logic [4:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    #1 chk(what, exp, rdata);
    @(posedge clk);
    #1 chk("rdata idle", 32'h0, rdata);
  endtask : rdchk

  // waits two edges so registered effects of the inputs have landed
  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  // writable fields come out of reset at zero, w[4] is bit 12, w[3:0] bits 3:0
  function automatic logic [31:0] exp_boot(input logic [26:0] m, input logic pin,
                                           input logic [4:0] w);
    return {m[25], m[7:5], m[4:1], 2'h1, m[17:16], 2'h0, m[12], m[20], m[8] | pin,
            2'h3, w[4], 3'h2, 3'h2, 2'h3, w[3:0]};
  endfunction : exp_boot

  // reset with a given stream, bounded wait for the capture
  task boot(input logic [26:0] m, input logic pin);
    int n;
    @(posedge clk);
    rstn           <= 1'h0;
    mode_bits      <= m;
    big_endian_pin <= pin;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    n = 0;
    while (boot_done !== 1'h1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    chk("boot_done", 32'h1, {31'h0, boot_done});
  endtask : boot

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_ident;
    rdchk(`CICSR_A_ID, {16'h0, 8'h5a, 4'h1, 4'h0}, "identity");
    wr(`CICSR_A_ID, 32'hffff_ffff);
    rdchk(`CICSR_A_ID, {16'h0, 8'h5a, 4'h1, 4'h0}, "identity after write");
    wr(5'h01, 32'hffff_ffff);
    rdchk(5'h01, 32'h0, "unmapped");
    $display("test ident done");
  endtask : t_ident

  // stream changes after capture must not reach the register
  task t_boot(input logic [26:0] m, input logic pin);
    rdchk(`CICSR_A_BOOT, exp_boot(m, pin, 5'h00),
          "boot reset");
    @(posedge clk);
    mode_bits <= ~m;
    rdchk(`CICSR_A_BOOT, exp_boot(m, pin, 5'h00), "boot held");
    wr(`CICSR_A_BOOT, 32'hffff_ffff);
    rdchk(`CICSR_A_BOOT, exp_boot(m, pin, 5'h1f), "boot ones");
    chk("enables", 32'h1f, {27'h0, l3_enable, l2_enable, kernel_segment_policy});
    wr(`CICSR_A_BOOT, 32'h0000_0005);
    #1 chk("enables b", 32'h5, {27'h0, l3_enable, l2_enable, kernel_segment_policy});
    rdchk(`CICSR_A_BOOT, exp_boot(m, pin, 5'h05), "boot mix");
    $display("test boot done");
  endtask : t_boot

  task t_mode;
    logic [1:0] pv [6];
    logic [1:0] nm [6];
    logic       fl [6];
    pv = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h0, 2'h0};
    nm = '{2'h1, 2'h2, 2'h0, 2'h3, 2'h0, 2'h2};
    fl = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1};
    wr(`CICSR_A_MODE, 32'hffff_ffff);
    rdchk(`CICSR_A_MODE, 32'hf200_ff00, "mode ones");
    wr(`CICSR_A_MODE, 32'ha200_a500);
    rdchk(`CICSR_A_MODE, 32'ha200_a500, "mode value");
    @(posedge clk);
    sw_int  <= 2'h3;
    ext_int <= 6'h3f;
    settle;
    chk("int mask", 32'h25, {24'h0, int_request});
    @(posedge clk);
    timer_int <= 1'h1;
    settle;
    chk("int timer", 32'ha5, {24'h0, int_request});
    @(posedge clk);
    priv <= cicsr_pkg::CICSR_USER;
    settle;
    chk("user order", 32'h1, {31'h0, data_big_endian});
    chk("user isa", 32'h1, {31'h0, ext_isa_ok});
    @(posedge clk);
    priv <= cicsr_pkg::CICSR_SUPER;
    settle;
    chk("super order", 32'h0, {31'h0, data_big_endian});
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      priv       <= cicsr_pkg::cicsr_priv_t'(pv[i]);
      cop_num    <= nm[i];
      cop_access <= 1'h1;
      @(posedge clk);
      cop_access <= 1'h0;
      #1 chk("cop_fault", {31'h0, fl[i]}, {31'h0, cop_fault});
      @(posedge clk);
      #1 chk("cop_fault end", 32'h0, {31'h0, cop_fault});
    end
    @(posedge clk);
    priv <= cicsr_pkg::CICSR_USER;
    wr(`CICSR_A_MODE, 32'h0200_a500);
    settle;
    chk("isa off", 32'h0, {31'h0, ext_isa_ok});
    $display("test mode done");
  endtask : t_mode

  // stream b routes line 7 to ext5, strap pin forces big endian
  task t_line7;
    wr(`CICSR_A_MODE, 32'h0000_8000);
    @(posedge clk);
    ext_int   <= 6'h1f;
    timer_int <= 1'h1;
    settle;
    chk("line7 timer", 32'h0, {24'h0, int_request});
    @(posedge clk);
    ext_int <= 6'h20;
    settle;
    chk("line7 ext5", 32'h80, {24'h0, int_request});
    chk("pin order", 32'h1, {31'h0, data_big_endian});
    $display("test line7 done");
  endtask : t_line7

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    boot(MA, 1'h0);
    t_ident;
    t_boot(MA, 1'h0);
    t_mode;
    boot(MB, 1'h1);
    t_boot(MB, 1'h1);
    t_line7;
    results;
  end

  // the run needs well under 500 cycles
  initial begin
    #20000;
    miscompares++;
    results;
  end
endmodule : tb_top
